/* design/hti_slave.sv */
// Purpose: I2C target for humidity and temperature commands.
// Assumes: SCL and SDA are open drain; the converter delivers results on a stream.
// Notes:   The converter itself lies outside; results queue in a FIFO.
`timescale 1ns/10ps
`include "hti_defs.svh"

module hti_fifo #(
    parameter int W  = 16,
    parameter int D  = 32,
    parameter int AW = $clog2(D)
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0]   cnt_r, cnt_nxt;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;

    // Ready is registered against the next count so it never overruns.
    assign cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_r     <= '0;
            rp_r     <= '0;
            cnt_r    <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            if (pop) rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            cnt_r    <= cnt_nxt;
            in_ready <= cnt_nxt != (AW + 1)'(D);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) mem[wp_r] <= in_data;
    end
endmodule

module hti_slave #(
    parameter int          CYC_PER_MS = `HTI_CLK_MHZ * 1000,
    parameter int          DEPTH      = 32,
    parameter logic [15:0] ID_CODE    = 16'h5a5a  // Arbitrary value.
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        res_valid,
    output logic             res_ready,
    input  wire logic [15:0] res_data,
    input  wire logic        low_supply,
    output logic             meas_req,
    output logic             meas_hum,
    output logic [1:0]       meas_res,
    output logic             heater_en,
    output logic             sleep,
    output logic [15:0]      id_code
);
    import hti_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ----------------------------------------------------------------
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, lv_m, lv_s;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
            {lv_m, lv_s}          <= 2'h0;
        end else begin
            {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
            {lv_m, lv_s}          <= {low_supply, lv_m};
        end
    end
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_c  = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_c   = scl_s & scl_p & ~sda_p & sda_s;

    // ----------------------------------------------------------------
    // Millisecond tick
    // ----------------------------------------------------------------
    logic [31:0] div_r;
    logic        ms_tick;
    always_ff @(posedge clk_sys) begin
        if (rst || div_r == 32'(CYC_PER_MS - 1)) div_r <= '0;
        else div_r <= div_r + 1'b1;
    end
    assign ms_tick = div_r == 32'(CYC_PER_MS - 1);

    // ----------------------------------------------------------------
    // State and decode
    // ----------------------------------------------------------------
    hti_state_t  st_r;
    hti_kind_t   kind_r;
    hti_act_t    act_r, dec_act;
    logic [3:0]  bits_r;
    logic [7:0]  sh_r, cfg_r;
    logic [23:0] q_r;
    logic [1:0]  left_r;
    logic [6:0]  tmr_r, lim;
    logic        pend_r, hold_r, hum_r, rdcfg_r, mack_r, dec_ack, dec_pop;

    wire cmd_th = sh_r == `HTI_CMD_T_HOLD;
    wire cmd_hh = sh_r == `HTI_CMD_H_HOLD;
    wire cmd_tp = sh_r == `HTI_CMD_T_POLL;
    wire cmd_hp = sh_r == `HTI_CMD_H_POLL;
    wire cmd_wr = sh_r == `HTI_CMD_WR;
    wire cmd_rd = sh_r == `HTI_CMD_RD;
    wire cmd_rs = sh_r == `HTI_CMD_RST;
    wire cmd_ms = cmd_th | cmd_hh | cmd_tp | cmd_hp;
    wire at8    = (st_r == S_RX) & scl_fall & (bits_r == 4'h8);
    wire fifo_v;
    wire [15:0] fifo_d;

    always_comb begin
        dec_ack = 1'b0;
        dec_act = A_SKIP;
        dec_pop = 1'b0;
        case (kind_r)
            K_ADDR: if (sh_r[7:1] == `HTI_ADDR) begin
                if (!sh_r[0]) begin
                    dec_ack = 1'b1;
                    dec_act = A_RX;
                end else if (rdcfg_r) begin
                    dec_ack = 1'b1;
                    dec_act = A_TX;
                end else if (pend_r && fifo_v) begin
                    dec_ack = 1'b1;
                    dec_act = A_TX;
                    dec_pop = 1'b1;
                end else if (pend_r && hold_r) begin
                    dec_ack = 1'b1;
                    dec_act = A_HOLD;
                end
                // A poll before the result exists goes unanswered.
            end
            K_CMD: begin
                dec_ack = cmd_ms | cmd_wr | cmd_rd | cmd_rs;
                dec_act = cmd_wr ? A_RX : (cmd_rs ? A_RST : A_SKIP);
            end
            K_DATA: dec_ack = 1'b1;
            default: dec_ack = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Result bytes and checksum
    // ----------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ `HTI_CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    wire       pop_w  = (at8 & dec_pop) | ((st_r == S_HOLD) & fifo_v);
    wire [7:0] res_hi = fifo_d[15:8];
    wire [7:0] res_lo = {fifo_d[7:2], hum_r, 1'b0};
    wire [7:0] res_cc = crc8(crc8(`HTI_CRC_INIT, res_hi), res_lo);
    wire [23:0] res_q = {res_hi, res_lo, res_cc};
    wire [7:0] cfg_dflt = (`HTI_CFG_RST & ~8'h04) | (cfg_r & 8'h04);

    hti_fifo #(.W(16), .D(DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   (res_data),
        .out_valid (fifo_v),
        .out_ready (pop_w),
        .out_data  (fifo_d)
    );

    // ----------------------------------------------------------------
    // Measurement limits
    // ----------------------------------------------------------------
    wire [1:0] res_sel = {cfg_r[7], cfg_r[0]};
    wire       new_hum = cmd_hh | cmd_hp;
    always_comb begin
        case ({new_hum, res_sel})
            3'h0:    lim = `HTI_T14_MS;
            3'h1:    lim = `HTI_T12_MS;
            3'h2:    lim = `HTI_T13_MS;
            3'h3:    lim = `HTI_T11_MS;
            3'h4:    lim = `HTI_H12_MS;
            3'h5:    lim = `HTI_H8_MS;
            3'h6:    lim = `HTI_H10_MS;
            default: lim = `HTI_H11_MS;
        endcase
    end
    wire meas_go  = at8 & (kind_r == K_CMD) & cmd_ms;
    wire late     = pend_r & ~fifo_v & (tmr_r == 7'h0);
    wire srst_go  = (st_r == S_RACK) & scl_fall & (act_r == A_RST);
    wire init_run = (st_r == S_INIT) & scl_s & ms_tick;

    // The result must arrive inside the documented limit; a late one is
    // abandoned so a stretched bus is never held for ever.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tmr_r <= `HTI_INIT_MS;
        end else if (srst_go) begin
            tmr_r <= `HTI_SRST_MS;
        end else if (meas_go) begin
            tmr_r <= lim;
        end else if ((init_run || (pend_r && ms_tick)) && tmr_r != 7'h0) begin
            tmr_r <= tmr_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_r   <= 1'b0;
            hold_r   <= 1'b0;
            hum_r    <= 1'b0;
            meas_req <= 1'b0;
            cfg_r    <= `HTI_CFG_RST;
            rdcfg_r  <= 1'b0;
        end else begin
            meas_req <= meas_go;
            if (srst_go) begin
                pend_r <= 1'b0;
                cfg_r  <= cfg_dflt;
            end else if (meas_go) begin
                pend_r <= 1'b1;
                hold_r <= cmd_th | cmd_hh;
                hum_r  <= new_hum;
                if (!cfg_r[`HTI_BIT_NOLD]) cfg_r <= cfg_dflt;
            end else if (pop_w) begin
                pend_r <= 1'b0;
                cfg_r[`HTI_BIT_LOWV] <= lv_s;
            end else if (late) begin
                pend_r <= 1'b0;
            end else if (at8 && kind_r == K_DATA) begin
                cfg_r <= (sh_r & `HTI_CFG_WMASK) | (cfg_r & ~`HTI_CFG_WMASK);
            end
            if (at8 && kind_r == K_CMD && dec_ack) rdcfg_r <= cmd_rd;
        end
    end

    // ----------------------------------------------------------------
    // Bus engine
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r   <= S_INIT;
            kind_r <= K_ADDR;
            act_r  <= A_SKIP;
            bits_r <= 4'h0;
            sh_r   <= 8'h00;
            q_r    <= 24'h0;
            left_r <= 2'h0;
            mack_r <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else if (st_r == S_INIT) begin
            if (tmr_r == 7'h0) st_r <= S_IDLE;
        end else if (start_c) begin
            st_r   <= S_RX;
            kind_r <= K_ADDR;
            bits_r <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            st_r   <= S_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (st_r)
                S_RX: if (scl_rise && bits_r != 4'h8) begin
                    sh_r   <= {sh_r[6:0], sda_s};
                    bits_r <= bits_r + 1'b1;
                end else if (at8) begin
                    st_r   <= dec_ack ? S_RACK : S_SKIP;
                    sda_oe <= dec_ack;
                    act_r  <= dec_act;
                    if (dec_pop) q_r <= res_q;
                    else q_r <= {cfg_r, 16'h0};
                    left_r <= dec_pop ? 2'h2 : 2'h0;
                end
                S_RACK: if (scl_fall) begin
                    sda_oe <= 1'b0;
                    bits_r <= 4'h0;
                    case (act_r)
                        A_RX: begin
                            st_r   <= S_RX;
                            kind_r <= (kind_r == K_ADDR) ? K_CMD : K_DATA;
                        end
                        A_TX: begin
                            st_r   <= S_TX;
                            sda_oe <= ~q_r[23];
                            sh_r   <= {q_r[22:16], 1'b0};
                            bits_r <= 4'h1;
                        end
                        A_HOLD: begin
                            st_r   <= S_HOLD;
                            scl_oe <= 1'b1;
                        end
                        A_RST: st_r <= S_INIT;
                        default: st_r <= S_SKIP;
                    endcase
                end
                S_HOLD: if (fifo_v) begin
                    st_r   <= S_TX;
                    scl_oe <= 1'b0;
                    q_r    <= res_q;
                    left_r <= 2'h2;
                    sda_oe <= ~res_hi[7];
                    sh_r   <= {res_hi[6:0], 1'b0};
                    bits_r <= 4'h1;
                end else if (late) begin
                    st_r   <= S_SKIP;
                    scl_oe <= 1'b0;
                end
                S_TX: if (scl_fall) begin
                    if (bits_r == 4'h8) begin
                        st_r   <= S_TACK;
                        sda_oe <= 1'b0;
                    end else begin
                        sda_oe <= ~sh_r[7];
                        sh_r   <= {sh_r[6:0], 1'b0};
                        bits_r <= bits_r + 1'b1;
                    end
                end
                S_TACK: if (scl_rise) begin
                    mack_r <= ~sda_s;
                end else if (scl_fall) begin
                    // A refused byte ends the read, so the checksum is skipped.
                    if (mack_r && left_r != 2'h0) begin
                        st_r   <= S_TX;
                        q_r    <= {q_r[15:0], 8'h00};
                        left_r <= left_r - 1'b1;
                        sda_oe <= ~q_r[15];
                        sh_r   <= {q_r[14:8], 1'b0};
                        bits_r <= 4'h1;
                    end else begin
                        st_r <= S_SKIP;
                    end
                end
                default: sda_oe <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_o     <= 1'b0;
            sda_o     <= 1'b0;
            meas_hum  <= 1'b0;
            meas_res  <= 2'h0;
            heater_en <= 1'b0;
            sleep     <= 1'b0;
            id_code   <= ID_CODE;
        end else begin
            meas_hum  <= hum_r;
            meas_res  <= res_sel;
            heater_en <= cfg_r[`HTI_BIT_HEAT];
            sleep     <= (st_r == S_IDLE) & ~pend_r;
        end
    end
endmodule

/* design/hti_defs.svh */
// Purpose: Constants of the humidity and temperature command slave.
// Assumes: 100 MHz clk_sys; times are kept in milliseconds.
// Notes:   Overview of the command set, bit layout and timing.
//
// Overview of operation
// - Idle and ready within 15 ms, SCL high.
// - Falls back to sleep when not busy.
// - Start and stop framed by SDA edges, SCL high.
// - Answers only address 1000000 plus direction bit.
// - Acknowledges accepted bytes after eighth falling edge.
// - E3/E5 start clock-stretching temperature/humidity measurements.
// - F3/F5 start polled measurements, SCL released.
// - E6 writes configuration, E7 makes it readable.
// - Stretching holds SCL low until result ready or limit expired.
// - Polled read header not acknowledged until done.
// - Two result LSBs carry status, bit1 humidity.
// - Temperature limit 85/43/22/11 ms by resolution.
// - FE reinitialises to defaults, keeps heater, under 15 ms.
// - Bits 7 and 0 select resolution, default 00.
// - Bit 6 flags low supply, refreshed per measurement.
// - Bit 2 switches the heater on.
// - Bit 1 low reloads defaults before measurements.
// - Results protected by CRC-8, polynomial 0x31.
// - Device holds a readable identification code.
// - Results sent as two bytes and a CRC byte, MSB first.
`ifndef HTI_DEFS_SVH
`define HTI_DEFS_SVH
`define HTI_ADDR       7'h40
`define HTI_CMD_T_HOLD 8'he3
`define HTI_CMD_H_HOLD 8'he5
`define HTI_CMD_T_POLL 8'hf3
`define HTI_CMD_H_POLL 8'hf5
`define HTI_CMD_WR     8'he6
`define HTI_CMD_RD     8'he7
`define HTI_CMD_RST    8'hfe
`define HTI_CFG_RST    8'h02
`define HTI_CFG_WMASK  8'h87
`define HTI_BIT_LOWV   6
`define HTI_BIT_HEAT   2
`define HTI_BIT_NOLD   1
`define HTI_CRC_POLY   8'h31
`define HTI_CRC_INIT   8'h00
`define HTI_CLK_MHZ    100
`define HTI_INIT_MS    7'd15
`define HTI_SRST_MS    7'd14
`define HTI_T14_MS     7'd85
`define HTI_T13_MS     7'd43
`define HTI_T12_MS     7'd22
`define HTI_T11_MS     7'd11
`define HTI_H12_MS     7'd29
`define HTI_H11_MS     7'd15
`define HTI_H10_MS     7'd9
`define HTI_H8_MS      7'd4
`endif

/* design/hti_pkg.sv */
// Purpose: Types shared by the command slave.
// Assumes: One-hot state codes.
// Notes:   Constants live in hti_defs.svh.
package hti_pkg;
    typedef enum logic [7:0] {
        S_INIT  = 8'h01, S_IDLE = 8'h02, S_RX   = 8'h04, S_RACK = 8'h08,
        S_HOLD  = 8'h10, S_TX   = 8'h20, S_TACK = 8'h40, S_SKIP = 8'h80
    } hti_state_t;
    typedef enum logic [2:0] {K_ADDR = 3'h1, K_CMD = 3'h2, K_DATA = 3'h4} hti_kind_t;
    typedef enum logic [4:0] {
        A_RX = 5'h01, A_TX = 5'h02, A_HOLD = 5'h04, A_SKIP = 5'h08, A_RST = 5'h10
    } hti_act_t;
endpackage

/* verification/hti_slave_assertions.sv */
// Purpose: Port-level checks of the humidity and temperature command slave.
// Assumes: One clock domain; rst is synchronous and active high.
// Notes:   Bound into every hti_slave instance.
`timescale 1ns/10ps
module hti_slave_chk #(
    parameter int          CYC_PER_MS = 100,
    parameter int          DEPTH      = 32,
    parameter logic [15:0] ID_CODE    = 16'h5a5a
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        res_valid,
    input wire logic        res_ready,
    input wire logic [15:0] res_data,
    input wire logic        low_supply,
    input wire logic        meas_req,
    input wire logic        meas_hum,
    input wire logic [1:0]  meas_res,
    input wire logic        heater_en,
    input wire logic        sleep,
    input wire logic [15:0] id_code
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_push;
        scl_oe && res_valid && res_ready;
    endsequence
    sequence s_free;
        ##[1:8] !scl_oe;
    endsequence
    property p_id;
        id_code == ID_CODE;
    endproperty
    property p_low_only;
        !scl_o && !sda_o;
    endproperty
    property p_init_quiet;
        $fell(rst) |-> (!sda_oe && !scl_oe && !meas_req)[*8];
    endproperty
    property p_req_pulse;
        meas_req |=> !meas_req;
    endproperty
    property p_req_awake;
        meas_req |-> !sleep;
    endproperty
    property p_sleep_quiet;
        sleep |-> !scl_oe && !sda_oe;
    endproperty
    property p_stretch_awake;
        scl_oe |-> !sleep;
    endproperty
    property p_release;
        s_push |-> s_free;
    endproperty
    property p_ack_stands;
        $rose(sda_oe) |-> sda_oe[*3];
    endproperty
    a_id: assert property (p_id) else $error("id code differs");
    a_low_only: assert property (p_low_only) else $error("pin driven high");
    a_init_quiet: assert property (p_init_quiet) else $error("active during init");
    a_req_pulse: assert property (p_req_pulse) else $error("request too long");
    a_req_awake: assert property (p_req_awake) else $error("asleep at request");
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("drives in sleep");
    a_stretch_awake: assert property (p_stretch_awake) else $error("stretch in sleep");
    a_release: assert property (p_release) else $error("stretch kept");
    a_ack_stands: assert property (p_ack_stands) else $error("short low drive");
endmodule

bind hti_slave hti_slave_chk #(
    .CYC_PER_MS(CYC_PER_MS), .DEPTH(DEPTH), .ID_CODE(ID_CODE)
) u_chk (
    .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .low_supply(low_supply),
    .meas_req(meas_req), .meas_hum(meas_hum), .meas_res(meas_res),
    .heater_en(heater_en), .sleep(sleep), .id_code(id_code)
);

/* verification/hti_i2c_master.sv */
// Purpose: Bus master model that drives the slave's two open-drain lines.
// Assumes: Pull-ups outside; an output high pulls its line low.
// Notes:   80 ns SCL period built from 20 ns quarter steps.
`timescale 1ns/10ps
module hti_i2c_master (
    input  wire logic clk_sys,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_oe,
    output logic      sda_oe,
    output logic      tmo
);
    // ----------------------------------------
    // Bit and byte tasks
    // ----------------------------------------
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        tmo = 1'b0;
    end
    task automatic q();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // A stretched clock is waited out, but bounded so a stuck line cannot hang.
    task automatic rise();
        int n = 0;
        scl_oe = 1'b0;
        #1;
        while (!scl_i && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20000) tmo = 1'b1;
    endtask
    task automatic start();
        sda_oe = 1'b0;
        q();
        rise();
        q();
        sda_oe = 1'b1;
        q();
        scl_oe = 1'b1;
        q();
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        q();
        rise();
        q();
        sda_oe = 1'b0;
        q();
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_oe = !b;
        q();
        rise();
        q();
        r = sda_i;
        q();
        scl_oe = 1'b1;
        q();
    endtask
    task automatic wr(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rd(output logic [7:0] v, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            v[i] = r;
        end
        bit_x(!ack, r);
    endtask
endmodule

/* verification/test_hti_slave.sv */
// Purpose: Self-checking bench of the command slave over its serial bus.
// Assumes: 100 clk_sys cycles stand for one millisecond.
// Notes:   A bench process stands in for the converter's result stream.
`timescale 1ns/10ps
module test_hti_slave;
    import hti_pkg::*;
    localparam int          CPM = 100;
    localparam logic [15:0] IDC = 16'h3c96; // Arbitrary value.
    logic        clk_sys, rst, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
    logic        m_scl_oe, m_sda_oe, tmo, res_valid, res_ready, low_supply;
    logic        meas_req, meas_hum, heater_en, sleep, a;
    logic [1:0]  meas_res;
    logic [15:0] res_data, id_code;
    logic [7:0]  d;
    int          bad_count, comparisons, k;
    // ----------------------------------------
    // Wiring
    // ----------------------------------------
    assign scl_i = !(scl_oe || m_scl_oe);
    assign sda_i = !(sda_oe || m_sda_oe);
    hti_slave #(.CYC_PER_MS(CPM), .DEPTH(32), .ID_CODE(IDC)) DUT (
        .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .low_supply(low_supply),
        .meas_req(meas_req), .meas_hum(meas_hum), .meas_res(meas_res),
        .heater_en(heater_en), .sleep(sleep), .id_code(id_code)
    );
    hti_i2c_master u_mst (
        .clk_sys(clk_sys), .scl_i(scl_i), .sda_i(sda_i),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .tmo(tmo)
    );
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge tmo) begin
        bad_count++;
        test_done();
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] crc(input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0]  c;
        logic [15:0] s;
        c = 8'h00;
        s = {b0, b1};
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ s[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic tx(input logic [7:0] v, input logic e);
        u_mst.wr(v, a);
        chk(16'(a), 16'(e));
    endtask
    task automatic rx(input logic [7:0] e, input logic ack);
        u_mst.rd(d, ack);
        chk(16'(d), 16'(e));
    endtask
    task automatic cfg_rd(output logic [7:0] v);
        u_mst.start();
        tx(8'h80, 1'b1);
        tx(8'he7, 1'b1);
        u_mst.start();
        tx(8'h81, 1'b1);
        u_mst.rd(v, 1'b0);
        u_mst.stop();
    endtask
    task automatic cmd(input logic [7:0] c);
        u_mst.start();
        tx(8'h80, 1'b1);
        tx(c, 1'b1);
    endtask
    task automatic push(input logic [15:0] w);
        int n = 0;
        res_data = w;
        res_valid = 1'b1;
        while (!res_ready && n < 100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        #1;
        res_valid = 1'b0;
        if (n >= 100) begin
            bad_count++;
            test_done();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        res_valid = 1'b0;
        res_data = 16'h0000;
        low_supply = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(16'({scl_oe, sda_oe, heater_en, sleep}), 16'h0000);
        chk(id_code, IDC);
        u_mst.start();
        tx(8'h80, 1'b0);
        u_mst.stop();
        repeat (16 * CPM) @(posedge clk_sys);
        #1;
        chk(16'(sleep), 16'h0001);
        cfg_rd(d);
        chk(16'(d), 16'h0002);
        cmd(8'he6);
        tx((d & 8'h38) | 8'h87, 1'b1);
        u_mst.stop();
        cfg_rd(d);
        chk(16'(d), 16'h0087);
        chk(16'({heater_en, meas_res}), 16'h0007);
        u_mst.start();
        tx(8'h82, 1'b0);
        u_mst.stop();
        u_mst.start();
        tx(8'h80, 1'b1);
        tx(8'h55, 1'b0);
        u_mst.stop();
        cfg_rd(d);
        chk(16'(d), 16'h0087);
        cmd(8'he3);
        chk(16'({meas_hum, meas_res}), 16'h0003);
        fork
            begin
                repeat (300) @(posedge clk_sys);
                #1;
                push(16'h6353);
            end
            begin
                u_mst.start();
                tx(8'h81, 1'b1);
                rx(8'h63, 1'b1);
                rx(8'h50, 1'b1);
                rx(crc(8'h63, 8'h50), 1'b0);
                u_mst.stop();
            end
        join
        low_supply = 1'b1;
        cmd(8'hf5);
        u_mst.stop();
        chk(16'({scl_oe, meas_hum}), 16'h0001);
        u_mst.start();
        tx(8'h81, 1'b0);
        u_mst.stop();
        push(16'h6350);
        u_mst.start();
        tx(8'h81, 1'b1);
        repeat (2000) @(posedge clk_sys);
        #1;
        rx(8'h63, 1'b1);
        rx(8'h52, 1'b0);
        u_mst.stop();
        cfg_rd(d);
        chk(16'(d), 16'h00c7);
        low_supply = 1'b0;
        cmd(8'hfe);
        u_mst.stop();
        repeat (15 * CPM) @(posedge clk_sys);
        #1;
        cfg_rd(d);
        chk(16'(d), 16'h0006);
        // The master stays idle while the stream fills the buffer to refusal.
        res_valid = 1'b1;
        for (k = 0; k < 40 && res_ready; k++) begin
            res_data = {k[7:0], 8'h00};
            @(posedge clk_sys);
            #1;
        end
        res_valid = 1'b0;
        chk(16'(k), 16'd32);
        for (k = 0; k < 33; k++) begin
            cmd(8'hf3);
            u_mst.start();
            u_mst.wr(8'h81, a);
            chk(16'(a), 16'(k < 32));
            if (a) begin
                u_mst.rd(d, 1'b0);
                chk(16'(d), 16'(k));
            end
            u_mst.stop();
        end
        test_done();
    end
endmodule
